// file: core/core_performance_monitor.sv
// core_performance_monitor: counters, selectors and axi4-lite slave
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
module core_performance_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire pmu_pkg::axi_req_type axi_req,
  output pmu_pkg::axi_rsp_type axi_rsp,
  input wire logic firmware_halt_state,
  input wire logic debugger_halt_state,
  input wire logic sleep_power_state,
  input wire pmu_pkg::core_events_type events
);

  pmu_pkg::state_type st_ff;
  pmu_pkg::state_type nxt_st;
  logic count_ok;
  logic active_power_state;
  logic [25:0] act_vec;
  logic [4:0] slp_vec;
  logic [3:0] hpm_hit;
  logic [5:0] inc;
  logic [5:0][63:0] cnt_inc;
  logic [3:0] status;
  logic wr_fire;
  pmu_pkg::dec_type wdec;
  pmu_pkg::dec_type rdec;
  logic [31:0] wold;
  logic [31:0] wval;

  function automatic logic [2:0] cnt_slot(input logic [4:0] n);
    logic [2:0] s;
    s = pmu_pkg::NO_SLOT;
    if (n == pmu_pkg::CNT_CYCLE)
      s = pmu_pkg::SLOT_CYCLE;
    else if (n == pmu_pkg::CNT_INSTRET)
      s = pmu_pkg::SLOT_INSTRET;
    else if (n >= pmu_pkg::HPM_FIRST && n <= pmu_pkg::HPM_LAST)
      s = 3'(n - pmu_pkg::HPM_FIRST) + pmu_pkg::SLOT_HPM0;
    return s;
  endfunction : cnt_slot

  function automatic pmu_pkg::dec_type decode(input logic [31:0] addr);
    pmu_pkg::dec_type d;
    logic [4:0] n;
    n = addr[6:2];
    d.kind = pmu_pkg::k_none;
    d.slot = pmu_pkg::NO_SLOT;
    d.sel = 2'h0;
    if (addr[31:9] == 23'h000000)
    begin
      case (addr[8:7])
        pmu_pkg::REG_LO, pmu_pkg::REG_HI:
        begin
          d.slot = cnt_slot(n);
          // unimplemented counter numbers read as zero
          if (d.slot == pmu_pkg::NO_SLOT)
            d.kind = pmu_pkg::k_zero;
          else if (addr[8:7] == pmu_pkg::REG_LO)
            d.kind = pmu_pkg::k_lo;
          else
            d.kind = pmu_pkg::k_hi;
        end
        pmu_pkg::REG_SEL:
        begin
          if (n >= pmu_pkg::HPM_FIRST && n <= pmu_pkg::HPM_LAST)
          begin
            d.kind = pmu_pkg::k_sel;
            d.sel = 2'(n - pmu_pkg::HPM_FIRST);
          end
          else if (n > pmu_pkg::HPM_LAST)
            d.kind = pmu_pkg::k_zero;
        end
        default:
        begin
          case (n)
            pmu_pkg::MISC_INH: d.kind = pmu_pkg::k_inh;
            pmu_pkg::MISC_CTL: d.kind = pmu_pkg::k_ctl;
            pmu_pkg::MISC_STAT: d.kind = pmu_pkg::k_stat;
            default: d.kind = pmu_pkg::k_none;
          endcase
        end
      endcase
    end
    return d;
  endfunction : decode

  function automatic logic [31:0] rd_word(
    input pmu_pkg::dec_type d,
    input pmu_pkg::state_type s,
    input logic [5:0][63:0] c,
    input logic [3:0] stat
  );
    logic [31:0] w;
    w = 32'h00000000;
    case (d.kind)
      pmu_pkg::k_lo: w = c[d.slot][31:0];
      pmu_pkg::k_hi: w = c[d.slot][63:32];
      pmu_pkg::k_sel: w = {22'h000000, s.sel[d.sel]};
      pmu_pkg::k_inh: w = {25'h0000000, s.inhibit & pmu_pkg::INH_MASK};
      pmu_pkg::k_ctl: w = {31'h00000000, s.stopcount};
      pmu_pkg::k_stat: w = {28'h0000000, stat};
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction : rd_word

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        m[b*8 +: 8] = data[b*8 +: 8];
    return m;
  endfunction : merge

  // selector decode; anything in the reserved gaps counts nothing
  function automatic logic event_hit(
    input logic [9:0] sel,
    input logic [25:0] av,
    input logic [4:0] sv,
    input logic act
  );
    logic h;
    h = 1'b0;
    if (sel == 10'h000)
      h = 1'b0;
    else if (sel <= pmu_pkg::ACT_LAST)
      h = act & av[sel[4:0]];
    else if (sel >= pmu_pkg::SLEEP_BASE && sel <= pmu_pkg::SEL_MAX)
      h = sv[sel[2:0]];
    return h;
  endfunction : event_hit

  // pause is deliberately not a term here: counting carries on
  assign count_ok = !firmware_halt_state &&
                    !(debugger_halt_state && st_ff.stopcount);
  assign active_power_state = !sleep_power_state;

  // bit index equals selector number
  assign act_vec = {
    events.branch_mispredict, events.branch_commit,
    events.commit_mret, events.commit_fence_i, events.commit_fence,
    events.commit_ecall, events.commit_ebreak,
    events.csr_write_x0, events.csr_rw, events.csr_read,
    events.commit_alu | events.commit_nop | events.commit_wfi,
    events.misalign_store, events.misalign_load,
    events.commit_store, events.commit_load,
    events.commit_div, events.commit_mul,
    events.decoded, events.aligned,
    events.commit_32b, events.commit_16b,
    events.commit_16b | events.commit_32b,
    events.fetch_miss, events.fetch_hit, 1'b1,
    1'b0
  };
  // sleep cycles and dma slave events, counted in sleep as well as active
  assign slp_vec = {
    events.dma_write & events.dma_to_dccm,
    events.dma_read & events.dma_to_dccm,
    events.dma_write, events.dma_read, sleep_power_state
  };

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_hpm
      // each counter looks only at its own selector
      assign hpm_hit[g] = event_hit(st_ff.sel[g], act_vec, slp_vec,
                                    active_power_state);
    end
  endgenerate

  assign status = {count_ok, sleep_power_state, debugger_halt_state,
                   firmware_halt_state};
  assign wr_fire = st_ff.aw_got && st_ff.w_got;
  assign wdec = decode(st_ff.awaddr);
  assign rdec = decode(axi_req.araddr);
  assign axi_rsp = st_ff.rsp;

  always_comb
  begin
    nxt_st = st_ff;
    inc[0] = count_ok && !st_ff.inhibit[pmu_pkg::INH_CYCLE];
    inc[1] = count_ok && !st_ff.inhibit[pmu_pkg::INH_INSTRET] &&
             (events.commit_16b || events.commit_32b);
    for (int i = 0; i < 4; i++)
      inc[i+2] = count_ok && !st_ff.inhibit[pmu_pkg::INH_HPM0 + i] &&
                 hpm_hit[i];
    // plain 64-bit add wraps from all ones to zero
    for (int i = 0; i < 6; i++)
    begin
      cnt_inc[i] = st_ff.cnt[i] + {63'h0, inc[i]};
      nxt_st.cnt[i] = cnt_inc[i];
    end

    if (axi_req.awvalid && st_ff.rsp.awready)
    begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_ff.rsp.wready)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = axi_req.wdata;
      nxt_st.wstrb = axi_req.wstrb;
    end

    // write merges onto the already-incremented value
    wold = rd_word(wdec, st_ff, cnt_inc, status);
    wval = merge(wold, st_ff.wdata, st_ff.wstrb);
    if (wr_fire)
    begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.rsp.bvalid = 1'b1;
      nxt_st.rsp.bresp = (wdec.kind == pmu_pkg::k_none) ?
                         pmu_pkg::RESP_SLVERR : pmu_pkg::RESP_OKAY;
      case (wdec.kind)
        pmu_pkg::k_lo:
          nxt_st.cnt[wdec.slot] = {cnt_inc[wdec.slot][63:32], wval};
        pmu_pkg::k_hi:
          nxt_st.cnt[wdec.slot] = {wval, cnt_inc[wdec.slot][31:0]};
        pmu_pkg::k_sel:
          // out-of-range selection clips to the top event
          nxt_st.sel[wdec.sel] = (wval > {22'h000000, pmu_pkg::SEL_MAX}) ?
                                 pmu_pkg::SEL_MAX : wval[9:0];
        pmu_pkg::k_inh:
          nxt_st.inhibit = wval[6:0] & pmu_pkg::INH_MASK;
        pmu_pkg::k_ctl:
          nxt_st.stopcount = wval[0];
        default:
          nxt_st.rsp.bresp = nxt_st.rsp.bresp; // zero and status: ignored
      endcase
    end
    if (st_ff.rsp.bvalid && axi_req.bready)
      nxt_st.rsp.bvalid = 1'b0;

    // read takes the value before this cycle's increment
    if (axi_req.arvalid && st_ff.rsp.arready)
    begin
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.rdata = rd_word(rdec, st_ff, st_ff.cnt, status);
      nxt_st.rsp.rresp = (rdec.kind == pmu_pkg::k_none) ?
                         pmu_pkg::RESP_SLVERR : pmu_pkg::RESP_OKAY;
    end
    else if (st_ff.rsp.rvalid && axi_req.rready)
      nxt_st.rsp.rvalid = 1'b0;

    // one write and one read in flight; ready drops until answered
    nxt_st.rsp.awready = !nxt_st.aw_got && !nxt_st.rsp.bvalid;
    nxt_st.rsp.wready = !nxt_st.w_got && !nxt_st.rsp.bvalid;
    nxt_st.rsp.arready = !nxt_st.rsp.rvalid;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      st_ff <= pmu_pkg::STATE_RST;
    else
      st_ff <= nxt_st;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_fw_halt_freeze;
    firmware_halt_state && !wr_fire |=> $stable(st_ff.cnt);
  endproperty
  a_fw_halt_freeze: assert property (p_fw_halt_freeze)
    else $error("counter moved during firmware halt");

  property p_dbg_stop;
    debugger_halt_state && st_ff.stopcount && !wr_fire |=> $stable(st_ff.cnt);
  endproperty
  a_dbg_stop: assert property (p_dbg_stop)
    else $error("counter moved in debug halt with stop-count set");

  property p_dma_uncounted;
    firmware_halt_state && events.dma_read && !wr_fire
      |=> st_ff.cnt[pmu_pkg::SLOT_HPM0] == $past(st_ff.cnt[pmu_pkg::SLOT_HPM0]);
  endproperty
  a_dma_uncounted: assert property (p_dma_uncounted)
    else $error("dma access counted during halt");

  property p_cycle_runs;
    !firmware_halt_state && !debugger_halt_state &&
      !st_ff.inhibit[pmu_pkg::INH_CYCLE] && !wr_fire
      |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) + 64'h1;
  endproperty
  a_cycle_runs: assert property (p_cycle_runs)
    else $error("cycle counter did not advance by one");

  property p_inhibit_hpm;
    st_ff.inhibit[pmu_pkg::INH_HPM0] && !wr_fire ##1 !wr_fire
      |=> $stable(st_ff.cnt[pmu_pkg::SLOT_HPM0]);
  endproperty
  a_inhibit_hpm: assert property (p_inhibit_hpm)
    else $error("inhibited counter advanced");

  property p_sel_zero;
    st_ff.sel[0] == 10'h000 && !wr_fire
      |=> $stable(st_ff.cnt[pmu_pkg::SLOT_HPM0]);
  endproperty
  a_sel_zero: assert property (p_sel_zero)
    else $error("counter with selector zero advanced");

  property p_warl_clip;
    wr_fire && wdec.kind == pmu_pkg::k_sel &&
      st_ff.wstrb == 4'hf && st_ff.wdata > 32'(pmu_pkg::SEL_MAX)
      |=> st_ff.sel[$past(wdec.sel)] == pmu_pkg::SEL_MAX;
  endproperty
  a_warl_clip: assert property (p_warl_clip)
    else $error("selector not clipped to highest event");

  property p_tied_zero;
    axi_req.arvalid && st_ff.rsp.arready && rdec.kind == pmu_pkg::k_zero
      |=> st_ff.rsp.rvalid && st_ff.rsp.rdata == 32'h00000000;
  endproperty
  a_tied_zero: assert property (p_tied_zero)
    else $error("unimplemented counter read not zero");

  property p_read_pending;
    axi_req.arvalid && st_ff.rsp.arready && rdec.kind == pmu_pkg::k_lo &&
      rdec.slot == pmu_pkg::SLOT_CYCLE && inc[0]
      |=> st_ff.rsp.rdata == $past(st_ff.cnt[0][31:0]);
  endproperty
  a_read_pending: assert property (p_read_pending)
    else $error("read took the increment of its own cycle");

  c_read: cover property (axi_req.arvalid && st_ff.rsp.arready);
  c_write: cover property (st_ff.rsp.bvalid && axi_req.bready);
  c_fw_halt: cover property (firmware_halt_state ##1 !firmware_halt_state);
  c_hpm_count: cover property (inc[2] ##1 inc[2]);

endmodule : core_performance_monitor
`default_nettype wire

// file: shared/pmu_pkg.sv
// package: performance monitor constants, types and state layout
`default_nettype none
package pmu_pkg;
  localparam logic [1:0] REG_LO = 2'h0;
  localparam logic [1:0] REG_HI = 2'h1;
  localparam logic [1:0] REG_SEL = 2'h2;
  localparam logic [1:0] REG_MISC = 2'h3;
  localparam logic [4:0] MISC_INH = 5'h00;
  localparam logic [4:0] MISC_CTL = 5'h01;
  localparam logic [4:0] MISC_STAT = 5'h02;
  localparam logic [4:0] CNT_CYCLE = 5'h00;
  localparam logic [4:0] CNT_INSTRET = 5'h02;
  localparam logic [4:0] HPM_FIRST = 5'h03;
  localparam logic [4:0] HPM_LAST = 5'h06;
  localparam logic [2:0] SLOT_CYCLE = 3'h0;
  localparam logic [2:0] SLOT_INSTRET = 3'h1;
  localparam logic [2:0] SLOT_HPM0 = 3'h2;
  localparam logic [2:0] NO_SLOT = 3'h7;
  localparam int INH_CYCLE = 0;
  localparam int INH_INSTRET = 2;
  localparam int INH_HPM0 = 3;
  localparam logic [6:0] INH_MASK = 7'h7d;
  localparam logic [9:0] ACT_LAST = 10'h019;
  localparam logic [9:0] SLEEP_BASE = 10'h200;
  localparam logic [9:0] SEL_MAX = 10'h204;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    k_none, k_lo, k_hi, k_sel, k_inh, k_ctl, k_stat, k_zero
  } reg_kind_type;

  typedef struct packed {
    reg_kind_type kind;
    logic [2:0] slot;
    logic [1:0] sel;
  } dec_type;

  typedef struct packed {
    logic fetch_hit;
    logic fetch_miss;
    logic commit_16b;
    logic commit_32b;
    logic aligned;
    logic decoded;
    logic commit_mul;
    logic commit_div;
    logic commit_load;
    logic commit_store;
    logic misalign_load;
    logic misalign_store;
    logic commit_alu;
    logic commit_nop;
    logic commit_wfi;
    logic csr_read;
    logic csr_rw;
    logic csr_write_x0;
    logic commit_ebreak;
    logic commit_ecall;
    logic commit_fence;
    logic commit_fence_i;
    logic commit_mret;
    logic branch_commit;
    logic branch_mispredict;
    logic dma_read;
    logic dma_write;
    logic dma_to_dccm;
  } core_events_type;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_type;

  typedef struct packed {
    logic [5:0][63:0] cnt;
    logic [3:0][9:0] sel;
    logic [6:0] inhibit;
    logic stopcount;
    logic aw_got;
    logic [31:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    axi_rsp_type rsp;
  } state_type;

  // counters, selectors, inhibit and stop-count all clear at reset
  localparam state_type STATE_RST = '0;
endpackage : pmu_pkg
`default_nettype wire

// file: test/event_source.sv
// event_source: far-side model driving one-cycle pipeline event pulses
`default_nettype none
module event_source (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic fire,
  input wire logic [27:0] mask,
  output var pmu_pkg::core_events_type events
);
  timeunit 1ns;
  timeprecision 1ps;
  // one cycle per event, as the pipeline reports them; quiet otherwise
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || !fire)
    begin
      events <= '0;
    end
    else
    begin
      events <= pmu_pkg::core_events_type'(mask);
    end
  end
endmodule : event_source
`default_nettype wire

// file: test/core_performance_monitor_tb.sv
// core_performance_monitor_tb: register-level tests over axi4-lite
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("ERROR %s exp %h got %h", nm, e, g); \
    end \
  end
module core_performance_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_b;
  pmu_pkg::axi_req_type axi_req;
  pmu_pkg::axi_rsp_type axi_rsp;
  pmu_pkg::core_events_type events;
  logic fw_halt, dbg_halt, sleep, fire;
  logic [27:0] mask;
  logic [31:0] v0, v1;
  logic [1:0] rsp;
  int error_cnt = 0;
  int n_tests = 0;
  int s;

  always #2.5 sys_clk = ~sys_clk;

  core_performance_monitor i_core_performance_monitor (
    .sys_clk(sys_clk), .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .firmware_halt_state(fw_halt), .debugger_halt_state(dbg_halt),
    .sleep_power_state(sleep), .events(events));

  event_source i_event_source (
    .sys_clk(sys_clk), .rst_b(rst_b), .fire(fire), .mask(mask),
    .events(events));

  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int t;
    @(posedge sys_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    for (t = 0; t < 40; t++)
    begin
      @(posedge sys_clk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) break;
    end
    axi_req.bready <= 1'b0;
    rsp = axi_rsp.bresp;
    if (t == 40) error_cnt++;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    int t;
    @(posedge sys_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    for (t = 0; t < 40; t++)
    begin
      @(posedge sys_clk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) break;
    end
    axi_req.rready <= 1'b0;
    d = axi_rsp.rdata;
    rsp = axi_rsp.rresp;
    if (t == 40) error_cnt++;
  endtask : rd

  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] g;
    rd(a, g);
    `CHK($sformatf("addr %h", a), e, g)
  endtask : rc

  // events reach the counter two edges after the pulse is requested
  task automatic pulse(input logic [27:0] m);
    @(posedge sys_clk);
    fire <= 1'b1;
    mask <= m;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : pulse

  // bit of the event that a selector in 2..25 follows
  function automatic logic [27:0] ev_bit(input int sel);
    int i;
    i = sel < 4 ? sel - 2 : sel == 4 ? 2 : sel < 16 ? sel - 3 : sel - 1;
    return 28'h1 << (27 - i);
  endfunction : ev_bit

  initial
  begin
    axi_req = '0;
    {fw_halt, dbg_halt, sleep, fire} = 4'h0;
    mask = '0;
    rst_b = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rc(32'h180, 32'h0);
    rc(32'h10c, 32'h0);
    rc(32'h188, 32'h8);
    wr(32'h11c, 32'h5);
    `CHK("bresp", pmu_pkg::RESP_OKAY, rsp)
    rc(32'h11c, 32'h0);
    wr(32'h01c, 32'h1234);
    rc(32'h01c, 32'h0);
    rd(32'h1a0, v0);
    `CHK("resp", pmu_pkg::RESP_SLVERR, rsp)
    wr(32'h1a0, 32'h1);
    `CHK("bresp", pmu_pkg::RESP_SLVERR, rsp)
    wr(32'h114, 32'hffff);
    rc(32'h114, {22'h0, pmu_pkg::SEL_MAX});
    pulse('1);
    rc(32'h010, 32'h0);
    wr(32'h180, 32'h7d);
    wr(32'h08c, 32'hffffffff);
    wr(32'h00c, 32'hffffffff);
    wr(32'h10c, 32'h5);
    rc(32'h08c, 32'hffffffff);
    rd(32'h008, v0);
    wr(32'h180, 32'h75);
    pulse(28'h2000000);
    rc(32'h00c, 32'h0);
    rc(32'h08c, 32'h0);
    rc(32'h008, v0);
    wr(32'h180, 32'h7b);
    pulse(28'h1000000);
    rc(32'h008, v0 + 32'h1);
    rd(32'h000, v0);
    rd(32'h000, v1);
    `CHK("cycle held", v0, v1)
    wr(32'h180, 32'h7a);
    rd(32'h000, v0);
    rd(32'h000, v1);
    `CHK("cycle runs", 1'b1, v1 != v0)
    fw_halt <= 1'b1;
    rd(32'h000, v0);
    rc(32'h000, v0);
    rc(32'h188, 32'h1);
    fw_halt <= 1'b0;
    // counters are inhibited around selector and value updates
    for (s = 2; s <= 25; s++)
    begin
      wr(32'h180, 32'h7d);
      wr(32'h10c, 32'(s));
      wr(32'h00c, 32'h0);
      wr(32'h180, 32'h75);
      pulse(ev_bit(s));
      pulse(ev_bit(s));
      pulse(~ev_bit(s));
      sleep <= 1'b1;
      pulse(ev_bit(s));
      sleep <= 1'b0;
      rc(32'h00c, 32'(2 + (s == 4 || s == 15)));
    end
    wr(32'h180, 32'h7d);
    wr(32'h10c, 32'h201);
    wr(32'h00c, 32'h0);
    wr(32'h180, 32'h75);
    pulse(28'h4);
    sleep <= 1'b1;
    pulse(28'h4);
    sleep <= 1'b0;
    fw_halt <= 1'b1;
    pulse(28'h4);
    fw_halt <= 1'b0;
    dbg_halt <= 1'b1;
    pulse(28'h4);
    wr(32'h184, 32'h1);
    rc(32'h184, 32'h1);
    rc(32'h188, 32'h2);
    pulse(28'h4);
    dbg_halt <= 1'b0;
    rc(32'h00c, 32'h3);
    // sleep held over four sampled edges gives four sleep cycles
    wr(32'h180, 32'h7d);
    wr(32'h10c, 32'h200);
    wr(32'h00c, 32'h0);
    wr(32'h180, 32'h75);
    sleep <= 1'b1;
    pulse(28'h0);
    sleep <= 1'b0;
    rc(32'h00c, 32'h4);
    end_sim();
  end

  // the tests need about a thousand cycles; this is ample headroom
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end
endmodule : core_performance_monitor_tb
`default_nettype wire
